// ===== src/gateway_pkg.sv
// Purpose: shared constants and types for the drive gateway status block
// Assumes: 10 MHz clock, classic wishbone register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package gateway_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC =
    CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned BLINK_W       = 22;

  localparam int unsigned IMG_BYTES     = 16;
  localparam int unsigned IMG_WORDS     = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
  localparam logic [7:0] OFS_IMG0    = 8'h10;

  // control register fields
  localparam int unsigned CTRL_PROFILE_LSB = 0;
  localparam int unsigned CTRL_ADDR_LSB    = 8;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // irq bit positions
  localparam int unsigned IRQ_PERIPH  = 0;
  localparam int unsigned IRQ_OFFLINE = 1;
  localparam int unsigned IRQ_LINK    = 2;
  localparam int unsigned IRQ_NEWDATA = 3;
  localparam int unsigned IRQ_W       = 4;

  typedef enum logic [1:0] {
    PROF_16B = 2'b00,
    PROF_8B  = 2'b01,
    PROF_4B  = 2'b10,
    PROF_2B  = 2'b11
  } profile_t;

  typedef struct packed {
    logic net_voltage;
    logic online;
    logic link_up;
    logic inv_error;
    logic inv_comm_fail;
    logic inv_activity;
  } status_in_t;

  typedef struct packed {
    logic network_voltage_lamp;
    logic fault_lamp;
    logic link_lamp;
    logic activity_lamp;
  } lamps_t;

  typedef struct packed {
    logic [15:0] in_word_status;
    logic [15:0] in_word_speed;
    logic [15:0] in_word_error;
    logic [15:0] in_word_torque;
    logic [15:0] in_word_digital_inputs;
    logic [15:0] in_word_op_mode;
    logic [15:0] in_word_position_high;
    logic [15:0] in_word_position_low;
  } inv_words_t;

endpackage

// ===== src/image_store.sv
// Purpose: registered store of the 16-byte input image
// Assumes: one write port of a whole image, word read port
// Notes:   read data come out of a register
`timescale 1ns/1ps
module image_store
  import gateway_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wr_i,
  input  wire logic [IMG_BYTES*8-1:0] wdata_i,
  input  wire logic [1:0]            raddr_i,
  output logic      [31:0]           rdata_o
);

  logic [IMG_BYTES*8-1:0] mem_q, mem_d;
  logic [31:0]            rdata_q, rdata_d;

  always_comb begin
    mem_d   = wr_i ? wdata_i : mem_q;
    rdata_d = mem_q[IMG_BYTES*8-1-32*raddr_i -: 32];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_q   <= '0;
      rdata_q <= '0;
    end else begin
      mem_q   <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule

// ===== src/drive_gateway_status.sv
// Purpose: lamp control, peripheral fault collection, input image packing
// Assumes: status inputs synchronous to clk_i; classic wishbone slave
// Notes:   image word 0 holds bytes 0..3, byte 0 in bits 31:24
`timescale 1ns/1ps

// Summary of operation
// - network lamp steady with voltage, flashing on fault or address 0.
// - network lamp dark whenever no network voltage is present.
// - fault lamp steady when the address is 0 or the node is offline.
// - fault lamp flashes on peripheral fault when online, else dark.
// - link lamp lit while the motor-side port has a network link.
// - activity lamp flashes while data flows with the inverter.
// - an inverter error counts as a peripheral fault.
// - lost inverter communication counts as a peripheral fault.
// - status word goes to bytes 0 and 1, high byte first.
// - torque word goes to bytes 6 and 7, high byte first.
// - digital input word goes to bytes 8 and 9, high byte first.
// - the usable image width follows the selected profile.
// - the default profile carries a sixteen byte image.
module drive_gateway_status
  import gateway_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire status_in_t  status_i,
  input  wire inv_words_t  words_i,
  input  wire logic        words_valid_i,
  output lamps_t           lamps_o,
  output logic      [IMG_BYTES*8-1:0] image_o,
  output logic             irq_o
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [IMG_BYTES*8-1:0] mask_img(
    input logic [IMG_BYTES*8-1:0] img, input profile_t p);
    logic [IMG_BYTES*8-1:0] m;
    case (p)
      PROF_16B: m = '1;
      PROF_8B:  m = {{64{1'b1}}, 64'h0};
      PROF_4B:  m = {{32{1'b1}}, 96'h0};
      PROF_2B:  m = {{16{1'b1}}, 112'h0};
      default:  m = '1;
    endcase
    return img & m;
  endfunction

  // blink timebase
  logic [BLINK_W-1:0] blink_cnt_q, blink_cnt_d;
  logic               blink_q, blink_d;

  always_comb begin
    blink_cnt_d = blink_cnt_q + BLINK_W'(1);
    blink_d     = blink_q;
    if (blink_cnt_q == BLINK_W'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_d = '0;
      blink_d     = ~blink_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
    end
  end

  // registers
  logic [31:0]       ctrl_q, ctrl_d;
  logic [IRQ_W-1:0]  irq_st_q, irq_st_d;
  logic [IRQ_W-1:0]  irq_msk_q, irq_msk_d;
  logic              ack_q, ack_d;
  logic [31:0]       rd_q, rd_d;
  logic              img_sel_q, img_sel_d;
  logic [31:0]       img_rd;
  logic              periph_fault;
  logic              addr_zero;
  logic              link_q, online_q;
  profile_t          profile;
  logic              req;
  logic [IRQ_W-1:0]  ev;

  assign profile      = profile_t'(ctrl_q[CTRL_PROFILE_LSB +: 2]);
  assign addr_zero    = ctrl_q[CTRL_ADDR_LSB +: 8] == 8'h00;
  assign periph_fault = status_i.inv_error
                      | status_i.inv_comm_fail;
  assign req          = cyc_i & stb_i & ~ack_q;

  always_comb begin
    ev = '0;
    ev[IRQ_PERIPH]  = periph_fault;
    ev[IRQ_OFFLINE] = online_q & ~status_i.online;
    ev[IRQ_LINK]    = link_q ^ status_i.link_up;
    ev[IRQ_NEWDATA] = words_valid_i;
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    irq_msk_d = irq_msk_q;
    irq_st_d  = irq_st_q;
    ack_d     = req;
    rd_d      = rd_q;
    img_sel_d = 1'b0;
    if (req && we_i) begin
      case (adr_i)
        OFS_CTRL:    ctrl_d = merge(ctrl_q, dat_i, sel_i);
        OFS_IRQ_MSK: irq_msk_d = sel_i[0] ? dat_i[IRQ_W-1:0] : irq_msk_q;
        OFS_IRQ_ST:  irq_st_d = sel_i[0] ?
                       irq_st_q & ~dat_i[IRQ_W-1:0] : irq_st_q;
        default:     ;
      endcase
    end
    // set wins over clear
    irq_st_d = irq_st_d | ev;
    if (req && !we_i) begin
      case (adr_i)
        OFS_CTRL:    rd_d = ctrl_q;
        OFS_STATUS:  rd_d = {26'h0, status_i.net_voltage,
                             status_i.online, status_i.link_up,
                             status_i.inv_error, status_i.inv_comm_fail,
                             status_i.inv_activity};
        OFS_IRQ_ST:  rd_d = {28'h0, irq_st_q};
        OFS_IRQ_MSK: rd_d = {28'h0, irq_msk_q};
        default: begin
          rd_d      = 32'h0000_0000;
          img_sel_d = adr_i[7:4] == OFS_IMG0[7:4];
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= CTRL_RESET;
      irq_st_q  <= '0;
      irq_msk_q <= '0;
      ack_q     <= 1'b0;
      rd_q      <= '0;
      img_sel_q <= 1'b0;
      link_q    <= 1'b0;
      online_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      irq_st_q  <= irq_st_d;
      irq_msk_q <= irq_msk_d;
      ack_q     <= ack_d;
      rd_q      <= rd_d;
      img_sel_q <= img_sel_d;
      link_q    <= status_i.link_up;
      online_q  <= status_i.online;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = img_sel_q ? img_rd : rd_q;
  assign irq_o = |(irq_st_q & irq_msk_q);

  // lamps
  lamps_t lamps_q, lamps_d;

  always_comb begin
    lamps_d = '0;
    if (status_i.net_voltage) begin
      lamps_d.network_voltage_lamp =
        (periph_fault | addr_zero) ? blink_q : 1'b1;
    end else begin
      lamps_d.network_voltage_lamp = 1'b0;
    end
    if (addr_zero || !status_i.online) begin
      lamps_d.fault_lamp = 1'b1;
    end else begin
      lamps_d.fault_lamp = periph_fault & blink_q;
    end
    lamps_d.link_lamp     = status_i.link_up;
    lamps_d.activity_lamp = status_i.inv_activity & blink_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamps_q <= '0;
    end else begin
      lamps_q <= lamps_d;
    end
  end

  assign lamps_o = lamps_q;

  // input image packing, high byte first
  logic [IMG_BYTES*8-1:0] img_packed;
  logic [IMG_BYTES*8-1:0] image_q, image_d;

  always_comb begin
    img_packed = {words_i.in_word_status,
                  words_i.in_word_speed,
                  words_i.in_word_error,
                  words_i.in_word_torque,
                  words_i.in_word_digital_inputs,
                  words_i.in_word_op_mode,
                  words_i.in_word_position_high,
                  words_i.in_word_position_low};
    image_d = words_valid_i ? mask_img(img_packed, profile)
                            : image_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      image_q <= '0;
    end else begin
      image_q <= image_d;
    end
  end

  assign image_o = image_q;

  image_store u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (words_valid_i),
    .wdata_i (image_d),
    .raddr_i (adr_i[3:2]),
    .rdata_o (img_rd)
  );

endmodule

// ===== verification/drive_gateway_status_sva.sv
// Purpose: port checker for drive_gateway_status
// Assumes: one clock, rst_i synchronous active high
// Notes:   flashing lamps are checked only where they must be dark or steadily lit
`timescale 1ns/1ps
module drive_gateway_status_sva
  import gateway_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   ack_o,
  input  wire status_in_t             status_i,
  input  wire inv_words_t             words_i,
  input  wire logic                   words_valid_i,
  input  wire lamps_t                 lamps_o,
  input  wire logic [IMG_BYTES*8-1:0] image_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  ack_cause_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked in one cycle");
  reset_dark_a: assert property ($fell(rst_i) |-> lamps_o == '0)
    else $error("lamp lit out of reset");
  net_dark_a: assert property (!status_i.net_voltage |=>
    !lamps_o.network_voltage_lamp) else $error("network lamp lit");
  link_lamp_a: assert property (1 |=>
    lamps_o.link_lamp == $past(status_i.link_up)) else $error("link lamp");
  act_dark_a: assert property (!status_i.inv_activity |=>
    !lamps_o.activity_lamp) else $error("activity lamp lit");
  offline_a: assert property (!status_i.online |=>
    lamps_o.fault_lamp) else $error("fault lamp dark while offline");
  img_status_a: assert property (words_valid_i |=>
    image_o[127:112] == $past(words_i.in_word_status))
    else $error("status word misplaced");
endmodule
bind drive_gateway_status drive_gateway_status_sva sva_inst (.clk_i, .rst_i,
  .cyc_i, .stb_i, .ack_o, .status_i, .words_i, .words_valid_i, .lamps_o,
  .image_o);

// ===== verification/inverter_model.sv
// Purpose: inverter side model feeding feedback words
// Assumes: send_i is a one-cycle request
// Notes:   words churn between captures so stale data shows up
`timescale 1ns/1ps
module inverter_model
  import gateway_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        send_i,
  input  wire logic [15:0] base_i,
  output inv_words_t       words_o = '0,
  output logic             valid_o = 1'b0
);
  always_ff @(posedge clk_i) begin
    valid_o <= send_i;
    if (send_i) begin
      for (int i = 0; i < 8; i++) begin
        words_o[127-16*i -: 16] <= base_i + 16'(i);
      end
    end else begin
      words_o <= ~words_o;
    end
  end
endmodule

// ===== verification/drive_gateway_status_bench.sv
// Purpose: self-checking bench for drive_gateway_status
// Assumes: run stays inside the first dark blink phase
// Notes:   a flashing lamp therefore reads dark
`timescale 1ns/1ps
module drive_gateway_status_bench
  import gateway_pkg::*;
();
  typedef struct packed { logic [5:0] st; lamps_t exp; } row_t;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic         we_i = 1'b0, send = 1'b0, ack_o, words_valid_i, irq_o;
  logic [7:0]   adr_i = 8'h00;
  logic [3:0]   sel_i = 4'hf;
  logic [31:0]  dat_i = 32'h0, dat_o, rd;
  logic [15:0]  base = 16'h0;
  status_in_t   status_i = '0;
  inv_words_t   words_i;
  lamps_t       lamps_o;
  logic [127:0] image_o;
  int           err_count = 0, checks = 0;
  row_t rows [7] = '{'{6'h30, 4'h8}, '{6'h10, 4'h0}, '{6'h20, 4'hc},
    '{6'h38, 4'ha}, '{6'h34, 4'h0}, '{6'h32, 4'h0}, '{6'h31, 4'h8}};
  drive_gateway_status drive_gateway_status_inst (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .status_i,
    .words_i, .words_valid_i, .lamps_o, .image_o, .irq_o);
  inverter_model inverter_model_inst (.clk_i, .send_i(send), .base_i(base),
    .words_o(words_i), .valid_o(words_valid_i));
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t no ack", $time);
      test_done();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic feed(input logic [15:0] b);
    @(posedge clk_i);
    send <= 1'b1;
    base <= b;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'h0000_0500);
    foreach (rows[i]) begin
      @(posedge clk_i);
      status_i <= rows[i].st;
      repeat (2) @(posedge clk_i);
      #1 chk(128'(lamps_o), 128'(rows[i].exp), "lamps");
    end
    $display("lamp rows done");
    wb(1'b1, OFS_CTRL, 32'h0);
    status_i <= 6'h30;
    repeat (2) @(posedge clk_i);
    #1 chk(128'(lamps_o), 128'h4, "address zero lamps");
    wb(1'b1, OFS_CTRL, 32'h0000_0500);
    feed(16'h1234);
    for (int i = 0; i < 8; i++) begin
      chk(128'(image_o[127-16*i -: 16]), 128'(16'h1234 + 16'(i)), "word");
    end
    wb(1'b0, OFS_IMG0, 32'h0);
    chk(128'(rd), 128'h1234_1235, "image read");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(128'(rd[5:0]), 128'h30, "status read");
    wb(1'b0, 8'h40, 32'h0);
    chk(128'(rd), 128'h0, "unmapped read");
    #1 chk(128'(irq_o), 128'h0, "irq masked");
    wb(1'b1, OFS_IRQ_MSK, 32'h9);
    #1 chk(128'(irq_o), 128'h1, "irq raised");
    wb(1'b1, OFS_IRQ_ST, 32'h9);
    #1 chk(128'(irq_o), 128'h0, "irq cleared");
    wb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(128'(rd), 128'h6, "offline and link events kept");
    $display("image and irq done");
    wb(1'b1, OFS_CTRL, 32'h0000_0503);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk(128'(rd), 128'h503, "ctrl readback");
    feed(16'habcd);
    chk(image_o, {16'habcd, 112'h0}, "profile width");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(128'(lamps_o), 128'h0, "lamps in reset");
    $display("profile and reset done");
    test_done();
  end
endmodule
